// ### tcu_pkg.sv
// Shared constants of the timer and capture unit
package tcu_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] TCU_CTRL0    = 12'h000;
  localparam logic [11:0] TCU_PRESET0  = 12'h004;
  localparam logic [11:0] TCU_TALLY0   = 12'h008;
  localparam logic [11:0] TCU_CTRL1    = 12'h040;
  localparam logic [11:0] TCU_PRESET1  = 12'h044;
  localparam logic [11:0] TCU_TALLY1   = 12'h048;
  localparam logic [11:0] TCU_CTRL2    = 12'h080;
  localparam logic [11:0] TCU_PRESET2  = 12'h084;
  localparam logic [11:0] TCU_TALLY2   = 12'h088;
  localparam logic [11:0] TCU_SNAP2    = 12'h08c;
  localparam logic [11:0] TCU_IRQ_STAT = 12'h100;
  localparam logic [11:0] TCU_IRQ_MASK = 12'h104;

  // ==========================================================
  // Control register fields
  localparam int unsigned TCU_B_PEND   = 0;
  localparam int unsigned TCU_B_IEN    = 1;
  localparam int unsigned TCU_B_RELOAD = 2;
  localparam int unsigned TCU_B_EN     = 5;
  localparam int unsigned TCU_B_EDGE   = 6;
  localparam int unsigned TCU_B_CAPP   = 8;
  localparam int unsigned TCU_B_CSEL   = 9;
  localparam int unsigned TCU_B_MODE   = 10;
  localparam int unsigned TCU_B_DIR    = 11;

  // Writable control bits, pending flags excluded
  localparam logic [31:0] TCU_CTL_WMASK_BASIC = 32'h0000_0026;
  localparam logic [31:0] TCU_CTL_WMASK_FULL  = 32'h0000_0ee6;

  // ==========================================================
  // Reset values and encodings
  localparam logic [31:0] TCU_CTL_RST  = 32'h0000_0000;
  localparam logic [31:0] TCU_PRE_RST  = 32'h0000_0000;
  localparam logic [31:0] TCU_TALLY_RST = 32'h0000_0000;
  localparam logic [3:0]  TCU_MASK_RST = 4'h0;
  localparam logic [1:0]  TCU_EDGE_FALL = 2'h0;
  localparam logic [1:0]  TCU_EDGE_RISE = 2'h1;
  localparam logic [1:0]  TCU_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  TCU_RESP_SLVERR = 2'h2;
  localparam int unsigned TCU_NUM_TIMERS = 3;
  localparam int unsigned TCU_CAP_BIT    = 3;

endpackage

// ### tcu_timer.sv
// One 32-bit timer: tick select, terminal detection, reload and capture
`timescale 1ns/1ns
module tcu_timer import tcu_pkg::*; #(
  parameter int unsigned W    = 32,
  parameter bit          FULL = 1'b0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         en,
  input  wire logic         reload,
  input  wire logic         dir,
  input  wire logic         mode,
  input  wire logic         clk_sel,
  input  wire logic [1:0]   edge_sel,
  input  wire logic [W-1:0] preset,
  input  wire logic         ext_rise,
  input  wire logic         ext_fall,
  output logic      [W-1:0] count,
  output logic      [W-1:0] snap,
  output logic              term,
  output logic              cap
);

  // ==========================================================
  // Selection
  logic [W-1:0] count_r;
  logic [W-1:0] snap_r;
  logic         en_d_r;
  logic         done_r;
  logic         term_r;
  logic         cap_r;

  wire          dir_up   = FULL && dir;
  wire          cap_mode = FULL && mode;
  // Both-edges choice wins whatever the low bit holds
  wire          edge_hit = edge_sel[1] ? (ext_rise | ext_fall) :
                           edge_sel[0] ? ext_rise : ext_fall;
  // Capture mode counts trigger edges; timer mode picks its source
  wire          tick     = cap_mode ? edge_hit :
                           (FULL && clk_sel) ? ext_rise : 1'b1;
  wire          at_end   = dir_up ? (count_r == preset) :
                                    (count_r == '0);
  wire [W-1:0]  start_v  = dir_up ? '0 : preset;
  wire [W-1:0]  step_v   = dir_up ? count_r + 1'b1 : count_r - 1'b1;
  wire          en_rise  = en && !en_d_r;

  // ==========================================================
  // Counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= TCU_TALLY_RST;
      snap_r  <= TCU_TALLY_RST;
      en_d_r  <= 1'b0;
      done_r  <= 1'b0;
      term_r  <= 1'b0;
      cap_r   <= 1'b0;
    end else begin
      en_d_r <= en;
      term_r <= 1'b0;
      cap_r  <= 1'b0;
      if (en_rise) begin
        count_r <= start_v;
        done_r  <= 1'b0;
      end else if (en && tick && !done_r) begin
        if (at_end) begin
          term_r <= 1'b1;
          if (reload)
            count_r <= start_v;
          else
            done_r <= 1'b1;
        end else begin
          count_r <= step_v;
        end
      end
      if (en && cap_mode && edge_hit) begin
        cap_r  <= 1'b1;
        snap_r <= count_r;
      end
    end
  end

  assign count = count_r;
  assign snap  = snap_r;
  assign term  = term_r;
  assign cap   = cap_r;

endmodule

// ### tcu_top.sv
// Timer and capture unit: AXI4-Lite registers, three timers, interrupts
`timescale 1ns/1ns
module tcu_top import tcu_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_in,
  output logic [2:0]       timer_terminal_interrupt,
  output logic             irq
);

  localparam int unsigned NT = TCU_NUM_TIMERS;

  // ==========================================================
  // State
  logic [31:0] ctl_r [NT];
  logic [31:0] pre_r [NT];
  logic [NT-1:0] pend_r;
  logic        capp_r;
  logic [3:0]  stat_r;
  logic [3:0]  mask_r;
  logic        irq_r;
  logic [NT-1:0] tirq_r;
  logic [2:0]  sync_r;
  logic        lvl_r;
  logic        aw_have_r, w_have_r, awready_r, wready_r, bvalid_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r;
  logic        arready_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] tally_w [NT];
  logic [31:0] snap_w  [NT];
  logic [NT-1:0] term_w;
  logic [NT-1:0] cap_w;

  // ==========================================================
  // External input: three stages, level accepted once two agree
  wire ext_stable = sync_r[1] == sync_r[2];
  wire ext_rise   = ext_stable && sync_r[2] && !lvl_r;
  wire ext_fall   = ext_stable && !sync_r[2] && lvl_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_r <= 3'h0;
      lvl_r  <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], ext_in};
      if (ext_stable)
        lvl_r <= sync_r[2];
    end
  end

  // ==========================================================
  // Timers
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    tcu_timer #(.W(32), .FULL(i == 2)) u_tmr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .en       (ctl_r[i][TCU_B_EN]),
      .reload   (ctl_r[i][TCU_B_RELOAD]),
      .dir      (ctl_r[i][TCU_B_DIR]),
      .mode     (ctl_r[i][TCU_B_MODE]),
      .clk_sel  (ctl_r[i][TCU_B_CSEL]),
      .edge_sel (ctl_r[i][TCU_B_EDGE+:2]),
      .preset   (pre_r[i]),
      .ext_rise (ext_rise),
      .ext_fall (ext_fall),
      .count    (tally_w[i]),
      .snap     (snap_w[i]),
      .term     (term_w[i]),
      .cap      (cap_w[i])
    );
  end

  // ==========================================================
  // Write channel: address and data taken in either order
  wire aw_ok  = s_axi_awvalid && awready_r;
  wire w_ok   = s_axi_wvalid && wready_r;
  wire do_wr  = aw_have_r && w_have_r && !bvalid_r;
  wire aw_nxt = do_wr ? 1'b0 : (aw_have_r | aw_ok);
  wire w_nxt  = do_wr ? 1'b0 : (w_have_r | w_ok);
  wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                       {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits = wdata_r & bmask;

  wire wa_ctl0 = awaddr_r == TCU_CTRL0;
  wire wa_ctl1 = awaddr_r == TCU_CTRL1;
  wire wa_ctl2 = awaddr_r == TCU_CTRL2;
  wire wa_pre0 = awaddr_r == TCU_PRESET0;
  wire wa_pre1 = awaddr_r == TCU_PRESET1;
  wire wa_pre2 = awaddr_r == TCU_PRESET2;
  wire wa_stat = awaddr_r == TCU_IRQ_STAT;
  wire wa_mask = awaddr_r == TCU_IRQ_MASK;
  wire wa_ro   = awaddr_r == TCU_TALLY0 || awaddr_r == TCU_TALLY1 ||
                 awaddr_r == TCU_TALLY2 || awaddr_r == TCU_SNAP2;
  wire wa_hit  = wa_ctl0 | wa_ctl1 | wa_ctl2 | wa_pre0 | wa_pre1 |
                 wa_pre2 | wa_stat | wa_mask | wa_ro;
  wire [NT-1:0] wr_ctl = {do_wr && wa_ctl2, do_wr && wa_ctl1,
                          do_wr && wa_ctl0};
  wire [NT-1:0] wr_pre = {do_wr && wa_pre2, do_wr && wa_pre1,
                          do_wr && wa_pre0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= TCU_RESP_OKAY;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      aw_have_r <= aw_nxt;
      w_have_r  <= w_nxt;
      awready_r <= !aw_nxt;
      wready_r  <= !w_nxt;
      if (aw_ok)
        awaddr_r <= {s_axi_awaddr[11:2], 2'h0};
      if (w_ok) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wa_hit ? TCU_RESP_OKAY : TCU_RESP_SLVERR;
      end else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Registers; a hardware set wins over a same-cycle clear
  wire [3:0] stat_set = {cap_w[2], term_w};
  wire [3:0] stat_clr = (do_wr && wa_stat) ? wbits[3:0] : 4'h0;
  wire [3:0] stat_nxt = (stat_r & ~stat_clr) | stat_set;
  wire       capp_clr = wr_ctl[2] && wbits[TCU_B_CAPP];
  wire       capp_nxt = (capp_r && !capp_clr) || cap_w[2];

  for (genvar i = 0; i < NT; i++) begin : g_reg
    localparam logic [31:0] WM = (i == 2) ? TCU_CTL_WMASK_FULL :
                                            TCU_CTL_WMASK_BASIC;
    wire pend_clr = wr_ctl[i] && wbits[TCU_B_PEND];
    wire pend_nxt = (pend_r[i] && !pend_clr) || term_w[i];
    wire line_src = (i == 2) ? (pend_nxt || capp_nxt) : pend_nxt;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_r[i]  <= TCU_CTL_RST;
        pre_r[i]  <= TCU_PRE_RST;
        pend_r[i] <= 1'b0;
        tirq_r[i] <= 1'b0;
      end else begin
        if (wr_ctl[i])
          ctl_r[i] <= (ctl_r[i] & ~(WM & bmask)) | (wbits & WM);
        if (wr_pre[i])
          pre_r[i] <= (pre_r[i] & ~bmask) | wbits;
        pend_r[i] <= pend_nxt;
        // Line follows the flag as a level, gated by its enable
        tirq_r[i] <= line_src && (wr_ctl[i] ?
                     wbits[TCU_B_IEN] || (ctl_r[i][TCU_B_IEN] &&
                     !bmask[TCU_B_IEN]) : ctl_r[i][TCU_B_IEN]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capp_r <= 1'b0;
      stat_r <= 4'h0;
      mask_r <= TCU_MASK_RST;
      irq_r  <= 1'b0;
    end else begin
      capp_r <= capp_nxt;
      stat_r <= stat_nxt;
      if (do_wr && wa_mask && wstrb_r[0])
        mask_r <= wdata_r[3:0];
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // ==========================================================
  // Read channel
  wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
  wire [31:0] ctl_rd [NT];
  for (genvar i = 0; i < NT; i++) begin : g_rd
    assign ctl_rd[i] = ctl_r[i] |
                       {23'h0, (i == 2) && capp_r, 7'h0, pend_r[i]};
  end
  // Count registers are read-only: writes to them answer OKAY and are dropped
  wire [31:0] rd_word =
    ra == TCU_CTRL0    ? ctl_rd[0] :
    ra == TCU_PRESET0  ? pre_r[0]  :
    ra == TCU_TALLY0   ? tally_w[0] :
    ra == TCU_CTRL1    ? ctl_rd[1] :
    ra == TCU_PRESET1  ? pre_r[1]  :
    ra == TCU_TALLY1   ? tally_w[1] :
    ra == TCU_CTRL2    ? ctl_rd[2] :
    ra == TCU_PRESET2  ? pre_r[2]  :
    ra == TCU_TALLY2   ? tally_w[2] :
    ra == TCU_SNAP2    ? snap_w[2] :
    ra == TCU_IRQ_STAT ? {28'h0, stat_r} :
    ra == TCU_IRQ_MASK ? {28'h0, mask_r} : 32'h0000_0000;
  wire rd_hit = ra == TCU_CTRL0 || ra == TCU_PRESET0 ||
                ra == TCU_TALLY0 || ra == TCU_CTRL1 ||
                ra == TCU_PRESET1 || ra == TCU_TALLY1 ||
                ra == TCU_CTRL2 || ra == TCU_PRESET2 ||
                ra == TCU_TALLY2 || ra == TCU_SNAP2 ||
                ra == TCU_IRQ_STAT || ra == TCU_IRQ_MASK;
  wire ar_ok  = s_axi_arvalid && arready_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= TCU_RESP_OKAY;
    end else if (ar_ok) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= rd_hit ? TCU_RESP_OKAY : TCU_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end else if (!rvalid_r)
      arready_r <= 1'b1;
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign timer_terminal_interrupt = tirq_r;
  assign irq = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  hold_when_off_a: assert property (
    !ctl_r[0][TCU_B_EN] |=> $stable(tally_w[0]))
    else $error("timer0 count moved while disabled");
  term_sets_pend_a: assert property (
    term_w[1] |=> pend_r[1])
    else $error("terminal event did not set pending");
  line_level_a: assert property (
    pend_r[0] && ctl_r[0][TCU_B_IEN] && !wr_ctl[0] |=> tirq_r[0])
    else $error("interrupt line dropped while pending");
  pend_keep_a: assert property (
    pend_r[0] && !(wr_ctl[0] && wbits[TCU_B_PEND]) |=> pend_r[0])
    else $error("pending cleared without a one written");
  down_zero_a: assert property (
    term_w[0] |-> $past(tally_w[0]) == 32'h0000_0000)
    else $error("down count ended away from zero");
  up_preset_a: assert property (
    term_w[2] && $past(ctl_r[2][TCU_B_DIR]) |->
    $past(tally_w[2]) == $past(pre_r[2]))
    else $error("up count ended away from preset");
  cap_mode_a: assert property (
    cap_w[2] |-> $past(ctl_r[2][TCU_B_MODE]))
    else $error("capture outside capture mode");
  cap_pend_a: assert property (
    cap_w[2] |=> capp_r ##0 stat_r[TCU_CAP_BIT])
    else $error("capture did not set its flags");
  rise_only_a: assert property (
    cap_w[2] && $past(ctl_r[2][TCU_B_EDGE+:2]) == TCU_EDGE_RISE |->
    $past(ext_rise))
    else $error("capture on a non-rising edge");
  stop_at_end_a: assert property (
    term_w[0] && !$past(ctl_r[0][TCU_B_RELOAD]) |->
    (tally_w[0] == 32'h0000_0000) [*3])
    else $error("one-shot timer did not stop");

  term_cov_c: cover property (term_w[0] ##1 tirq_r[0]);
  reload_cov_c: cover property (term_w[2] ##[1:20] term_w[2]);
  cap_cov_c: cover property (cap_w[2] ##1 irq_r);
  w1c_cov_c: cover property (pend_r[1] ##1 !pend_r[1]);

endmodule

// ### tcu_top_tb.sv
// Self-checking testbench of the timer and capture unit
`timescale 1ns/1ns
module tcu_top_tb import tcu_pkg::*;;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0]  r;
  } tcu_row_t;

  // ==========================================================
  // Signals
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        ext_in  = 1'b0;
  logic [2:0]  tti;
  logic        irq;
  int          n_mismatch  = 0;
  int          check_count = 0;

  localparam logic [11:0] RA [12] = '{TCU_CTRL0, TCU_PRESET0, TCU_TALLY0,
    TCU_CTRL1, TCU_PRESET1, TCU_TALLY1, TCU_CTRL2, TCU_PRESET2, TCU_TALLY2,
    TCU_SNAP2, TCU_IRQ_STAT, TCU_IRQ_MASK};
  localparam tcu_row_t ROWS [11] = '{
    '{TCU_PRESET0,  32'hdead_beef, 32'hdead_beef, TCU_RESP_OKAY},
    '{TCU_PRESET1,  32'h1234_5678, 32'h1234_5678, TCU_RESP_OKAY},
    '{TCU_PRESET2,  32'ha5a5_5a5a, 32'ha5a5_5a5a, TCU_RESP_OKAY},
    '{TCU_TALLY0,   32'hffff_ffff, 32'h0000_0000, TCU_RESP_OKAY},
    '{TCU_TALLY1,   32'hffff_ffff, 32'h0000_0000, TCU_RESP_OKAY},
    '{TCU_TALLY2,   32'hffff_ffff, 32'h0000_0000, TCU_RESP_OKAY},
    '{TCU_SNAP2,    32'hffff_ffff, 32'h0000_0000, TCU_RESP_OKAY},
    '{TCU_CTRL1,    32'hffff_ffdf, 32'h0000_0006, TCU_RESP_OKAY},
    '{TCU_CTRL2,    32'hffff_ffdf, 32'h0000_0ec6, TCU_RESP_OKAY},
    '{TCU_IRQ_MASK, 32'hffff_ffff, 32'h0000_000f, TCU_RESP_OKAY},
    '{12'h0fc,      32'h1234_5678, 32'h0000_0000, TCU_RESP_SLVERR}};

  always #50 aclk = ~aclk;

  tcu_top tcu_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_in(ext_in),
    .timer_terminal_interrupt(tti), .irq(irq));

  // ==========================================================
  // Checking and report
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic timeout;
    n_mismatch++;
    $display("BAD %0t no answer in time", $time);
    end_of_test();
  endtask

  // Ends just after an edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 100) timeout();
  endtask

  task automatic wo(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 100) timeout();
  endtask

  task automatic wait_hi(input int idx);
    int n;
    for (n = 0; n < 300; n++) begin
      settle(1);
      if (tti[idx] === 1'b1) break;
    end
    if (n == 300) timeout();
  endtask

  // Held long enough to pass the three-stage synchroniser
  task automatic pulse;
    @(posedge aclk);
    ext_in <= 1'b1;
    settle(10);
    @(posedge aclk);
    ext_in <= 1'b0;
    settle(10);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [31:0] c1;
    logic [1:0]  r;
    int          i;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    chk32({28'h0, tti, irq}, 32'h0);
    for (i = 0; i < 12; i++) begin
      rd(RA[i], v, r);
      chk32(v, 32'h0);
    end
    for (i = 0; i < 11; i++) begin
      wr(ROWS[i].a, ROWS[i].d, r);
      chk32({30'h0, r}, {30'h0, ROWS[i].r});
      rd(ROWS[i].a, v, r);
      chk32(v, ROWS[i].q);
      chk32({30'h0, r}, {30'h0, ROWS[i].r});
    end
    wo(TCU_IRQ_MASK, 32'h0);
    // Timer0 one-shot down count, level line, write-one clear
    wo(TCU_PRESET0, 32'h5);
    wo(TCU_CTRL0, 32'h22);
    wait_hi(0);
    rd(TCU_TALLY0, v, r);
    chk32(v, 32'h0);
    settle(30);
    chkb(tti[0], 1'b1);
    chkb(irq, 1'b0);
    wo(TCU_IRQ_MASK, 32'h1);
    settle(3);
    chkb(irq, 1'b1);
    wo(TCU_IRQ_STAT, 32'h1);
    settle(3);
    chkb(irq, 1'b0);
    wo(TCU_CTRL0, 32'h22);
    settle(3);
    chkb(tti[0], 1'b1);
    wo(TCU_CTRL0, 32'h23);
    settle(3);
    chkb(tti[0], 1'b0);
    settle(30);
    chkb(tti[0], 1'b0);
    // Timer1 reload gives a second event after clearing
    wo(TCU_PRESET1, 32'h28);
    wo(TCU_CTRL1, 32'h26);
    wait_hi(1);
    wo(TCU_CTRL1, 32'h27);
    settle(3);
    chkb(tti[1], 1'b0);
    wait_hi(1);
    wo(TCU_CTRL1, 32'h1);
    // Disabled timer holds its count
    wo(TCU_PRESET1, 32'h1000);
    wo(TCU_CTRL1, 32'h20);
    settle(50);
    wo(TCU_CTRL1, 32'h0);
    rd(TCU_TALLY1, c1, r);
    settle(40);
    rd(TCU_TALLY1, v, r);
    chk32(v, c1);
    chkb(c1 < 32'h1000 && c1 > 32'h0f00, 1'b1);
    // Timer2 down ends at zero, up ends at the preset
    wo(TCU_PRESET2, 32'h4);
    for (i = 0; i < 2; i++) begin
      wo(TCU_CTRL2, 32'h101);
      wo(TCU_CTRL2, (i == 1) ? 32'h822 : 32'h22);
      wait_hi(2);
      rd(TCU_TALLY2, v, r);
      chk32(v, (i == 1) ? 32'h4 : 32'h0);
    end
    // External clock source counts only ext_in rising edges
    wo(TCU_CTRL2, 32'h101);
    wo(TCU_PRESET2, 32'hff);
    wo(TCU_CTRL2, 32'ha20);
    settle(30);
    rd(TCU_TALLY2, v, r);
    chk32(v, 32'h0);
    for (i = 0; i < 3; i++) pulse();
    rd(TCU_TALLY2, v, r);
    chk32(v, 32'h3);
    // Capture mode with every edge choice; snapshot holds the old count
    for (i = 0; i < 4; i++) begin
      wo(TCU_CTRL2, 32'h101);
      wo(TCU_CTRL2, 32'hc22 | (i << 6));
      pulse();
      chkb(tti[2], 1'b1);
      rd(TCU_TALLY2, v, r);
      chk32(v, (i >= 2) ? 32'h2 : 32'h1);
      rd(TCU_SNAP2, v, r);
      chk32(v, (i >= 2) ? 32'h1 : 32'h0);
      rd(TCU_CTRL2, v, r);
      chkb(v[8], 1'b1);
      wo(TCU_CTRL2, 32'h100);
      rd(TCU_CTRL2, v, r);
      chkb(v[8], 1'b0);
    end
    // Reset in mid-run: line, preset and mask must all come back as zero
    wo(TCU_IRQ_MASK, 32'hf);
    wo(TCU_PRESET0, 32'h77);
    settle(2);
    chkb(irq, 1'b1);
    @(posedge aclk);
    aresetn <= 1'b0;
    settle(3);
    @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    chk32({28'h0, tti, irq}, 32'h0);
    rd(TCU_PRESET0, v, r);
    chk32(v, TCU_PRE_RST);
    rd(TCU_IRQ_MASK, v, r);
    chk32(v, {28'h0, TCU_MASK_RST});
    end_of_test();
  end
endmodule
